/* File: hw/bcs_pkg.sv */
// package: constants for the board control and status block
package bcs_pkg;
   localparam logic [6:0] SLAVE_ADDR    = 7'h5C;
   localparam logic [7:0] CMD_CTRL_WR   = 8'hA0;
   localparam logic [7:0] CMD_CTRL_RD   = 8'hA1;
   localparam logic [7:0] STATUS_REG_ZERO_WR  = 8'hB0;
   localparam logic [7:0] STATUS_REG_ZERO_RD  = 8'hB1;
   localparam logic [7:0] WATCHDOG_RAIL_STATUS_CLEAR  = 8'hB2;
   localparam logic [7:0] WATCHDOG_RAIL_STATUS_READ  = 8'hB3;
   localparam logic [7:0] CMD_REV_RD    = 8'hC1;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam int B_GREEN   = 7;
   localparam int B_HDIS    = 6;
   localparam int B_HRST    = 5;
   localparam int B_WSEL_A  = 4;
   localparam int B_WSEL_B  = 3;
   localparam int B_KICK    = 2;
   localparam int B_RED     = 1;
   localparam int B_SWRST   = 0;
   localparam int S0_1V8    = 7;
   localparam int S0_1V35   = 4;
   localparam int S1_ARMED  = 7;
   localparam int S1_WDRST  = 6;
   localparam int S1_HALF   = 5;
   localparam int S1_12V    = 4;
   localparam int S1_5V     = 3;
   localparam int S1_3V3    = 0;
   localparam int WD_T0_S   = 2;
   localparam int WD_T1_S   = 10;
   localparam int WD_T2_S   = 50;
   localparam int WD_T3_S   = 250;
   localparam int CLK_HZ    = 100_000_000;
   localparam int TICK_HZ   = 1000;
   localparam int TICK_CYC  = CLK_HZ / TICK_HZ;
   localparam logic [7:0] REV_DEFAULT = 8'h01;
endpackage : bcs_pkg

/* File: hw/bcs_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module bcs_sync #(
   // reset level, the idle level of the pin
   parameter logic RST_VAL = 1'b1
) (
   // clock, reset and enable
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // async pin in, filtered level out
   input  wire logic din,
   output var  logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         dout <= RST_VAL;
      end else if (ce) begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) dout <= s3_q;
      end
   end
endmodule : bcs_sync
`default_nettype wire

/* File: hw/bcs_top.sv */
// smbus slave with board control, status and watchdog
`timescale 1ns/1ns
`default_nettype none
module bcs_top #(
   parameter logic [7:0] REVISION  = bcs_pkg::REV_DEFAULT, // arbitrary value
   parameter int         TICK_CYCLES = bcs_pkg::TICK_CYC
) (
   // clock, reset, enable
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // smbus pins
   input  wire logic smb_clk_in,
   input  wire logic smb_dat_in,
   output var  logic smb_dat_out,
   output var  logic smb_dat_oe,
   // rail monitors and switch, active high
   input  wire logic rail_1v8_fail,
   input  wire logic rail_1v35_fail,
   input  wire logic rail_5v_fail,
   input  wire logic rail_3v3_fail,
   input  wire logic rail_12v_absent,
   input  wire logic handle_switch,
   // board controls
   output var  logic green_led_on,
   output var  logic red_led_blink,
   output var  logic sys_reset_req,
   output var  logic power_event_req
);
   import bcs_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_CMD  = 6'b000100,
      ST_WDAT = 6'b001000,
      ST_RDAT = 6'b010000,
      ST_SKIP = 6'b100000
   } bcs_state_e;

   // synchronised inputs
   logic [10:0] pin_raw;
   logic [10:0] pin_s;
   assign pin_raw = {handle_switch, rail_12v_absent, rail_3v3_fail, rail_5v_fail,
                     rail_1v35_fail, rail_1v8_fail, 3'b000, smb_dat_in, smb_clk_in};
   genvar gi;
   generate
      for (gi = 0; gi < 11; gi++) begin : g_sync
         if (gi < 2 || gi > 4) begin : g_on
            localparam logic IDLE_V = gi < 2 ? 1'b1 : 1'b0;
            bcs_sync #(.RST_VAL(IDLE_V)) u_sync (
               .clk   (clk),
               .rst_n (rst_n),
               .ce    (ce),
               .din   (pin_raw[gi]),
               .dout  (pin_s[gi])
            );
         end else begin : g_off
            assign pin_s[gi] = 1'b0;
         end
      end
   endgenerate

   logic scl;
   logic sda;
   logic scl_q;
   logic sda_q;
   assign scl = pin_s[0];
   assign sda = pin_s[1];

   wire scl_rise = scl & ~scl_q;
   wire scl_fall = ~scl & scl_q;
   wire start_c  = scl & scl_q & sda_q & ~sda;
   wire stop_c   = scl & scl_q & ~sda_q & sda;

   // smbus engine state
   bcs_state_e st_q;
   logic [7:0] sh_q;
   logic [3:0] bit_q;
   logic [7:0] cmd_q;
   logic       ack_q;
   logic       ackph_q;
   logic       rdir_q;
   logic       have_cmd_q;
   logic [7:0] tx_q;

   // registers
   logic [7:0] ctrl_q;
   logic [7:0] stat0_q;
   logic [7:0] stat1_q;
   logic       armed_q;
   logic       half_q;
   logic [31:0] tick_q;
   logic [31:0] ms_q;
   logic       sysrst_q;
   logic       hs_q;

   // byte boundaries
   wire byte_done = scl_rise && bit_q == 4'd7 && !ackph_q;
   wire [7:0] byte_in = {sh_q[6:0], sda};
   wire addr_hit  = byte_in[7:1] == SLAVE_ADDR;
   wire wr_fire   = byte_done && st_q == ST_WDAT;
   wire wr_ctrl   = wr_fire && cmd_q == CMD_CTRL_WR;
   wire wr_s0     = wr_fire && cmd_q == STATUS_REG_ZERO_WR;
   wire wr_s1     = wr_fire && cmd_q == WATCHDOG_RAIL_STATUS_CLEAR;

   // read mux
   wire [7:0] s1_view = {armed_q, stat1_q[6], half_q, pin_s[9],
                         stat1_q[3], 2'b00, stat1_q[0]};
   wire [7:0] rd_val  = cmd_q == CMD_CTRL_RD  ? ctrl_q :
                        cmd_q == STATUS_REG_ZERO_RD ? (stat0_q & 8'h90) :
                        cmd_q == WATCHDOG_RAIL_STATUS_READ ? s1_view :
                        cmd_q == CMD_REV_RD   ? REVISION : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // protocol engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q        <= ST_IDLE;
         sh_q        <= 8'h00;
         bit_q       <= 4'd0;
         cmd_q       <= 8'h00;
         ack_q       <= 1'b0;
         ackph_q     <= 1'b0;
         rdir_q      <= 1'b0;
         have_cmd_q  <= 1'b0;
         tx_q        <= 8'h00;
         smb_dat_out <= 1'b0;
         smb_dat_oe  <= 1'b0;
      end else if (ce) begin
         smb_dat_out <= 1'b0;
         if (start_c) begin
            st_q       <= ST_ADDR;
            bit_q      <= 4'd0;
            ackph_q    <= 1'b0;
            smb_dat_oe <= 1'b0;
         end else if (stop_c) begin
            st_q       <= ST_IDLE;
            have_cmd_q <= 1'b0;
            smb_dat_oe <= 1'b0;
         end else if (st_q != ST_IDLE && st_q != ST_SKIP) begin
            if (scl_rise && !ackph_q) begin
               sh_q  <= byte_in;
               bit_q <= bit_q + 4'd1;
               if (bit_q == 4'd7) begin
                  ackph_q <= 1'b1;
                  bit_q   <= 4'd0;
                  ack_q   <= 1'b0;
                  unique case (st_q)
                     ST_ADDR: begin
                        ack_q  <= addr_hit;
                        rdir_q <= byte_in[0];
                     end
                     ST_CMD: begin
                        ack_q      <= 1'b1;
                        cmd_q      <= byte_in;
                        have_cmd_q <= 1'b1;
                     end
                     ST_WDAT: ack_q <= 1'b1;
                     ST_RDAT: ack_q <= 1'b0;
                     default: ack_q <= 1'b0;
                  endcase
               end
            end else if (scl_rise && ackph_q && st_q == ST_RDAT) begin
               if (sda) st_q <= ST_SKIP;
            end
            if (scl_fall) begin
               if (ackph_q && bit_q == 4'd0 && ack_q) begin
                  smb_dat_oe <= 1'b1;
                  ack_q      <= 1'b0;
               end else if (ackph_q) begin
                  ackph_q    <= 1'b0;
                  smb_dat_oe <= 1'b0;
                  unique case (st_q)
                     ST_ADDR: begin
                        if (!ack_q && smb_dat_oe) begin
                           if (rdir_q && have_cmd_q) begin
                              st_q       <= ST_RDAT;
                              tx_q       <= rd_val;
                              smb_dat_oe <= ~rd_val[7];
                           end else if (rdir_q) st_q <= ST_SKIP;
                           else st_q <= ST_CMD;
                        end else st_q <= ST_SKIP;
                     end
                     ST_CMD:  st_q <= ST_WDAT;
                     ST_WDAT: st_q <= ST_SKIP;
                     ST_RDAT: st_q <= ST_SKIP;
                     default: st_q <= ST_SKIP;
                  endcase
               end else if (st_q == ST_RDAT) begin
                  tx_q       <= {tx_q[6:0], 1'b1};
                  smb_dat_oe <= bit_q != 4'd0 && !tx_q[6];
                  if (bit_q == 4'd0) smb_dat_oe <= 1'b0;
               end
            end
         end
      end
   end

   // control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (ce) begin
         if (sysrst_q) ctrl_q <= CTRL_RESET;
         else if (wr_ctrl) ctrl_q <= sh_q[6:0] == 7'h00 ? {7'h00, sda} : byte_in;
      end
   end

   // watchdog
   wire kick = wr_ctrl && byte_in[B_KICK] != ctrl_q[B_KICK];
   wire [1:0] wsel = {ctrl_q[B_WSEL_B], ctrl_q[B_WSEL_A]};
   wire [31:0] lim_ms = wsel == 2'b00 ? WD_T0_S * 1000 :
                        wsel == 2'b01 ? WD_T1_S * 1000 :
                        wsel == 2'b10 ? WD_T2_S * 1000 : WD_T3_S * 1000;
   wire tick    = tick_q == TICK_CYCLES - 1;
   wire expire  = armed_q && !kick && tick && ms_q + 32'd1 >= lim_ms;
   wire hs_edge = pin_s[10] && !hs_q && !ctrl_q[B_HDIS];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q   <= 32'd0;
         ms_q     <= 32'd0;
         armed_q  <= 1'b0;
         half_q   <= 1'b0;
         sysrst_q <= 1'b0;
         hs_q     <= 1'b0;
      end else if (ce) begin
         hs_q     <= pin_s[10];
         sysrst_q <= (wr_ctrl && byte_in[B_SWRST]) || expire ||
                     (hs_edge && ctrl_q[B_HRST]);
         tick_q   <= tick ? 32'd0 : tick_q + 32'd1;
         if (sysrst_q) begin
            armed_q <= 1'b0;
            half_q  <= 1'b0;
            ms_q    <= 32'd0;
         end else if (kick) begin
            armed_q <= 1'b1;
            half_q  <= 1'b0;
            ms_q    <= 32'd0;
            tick_q  <= 32'd0;
         end else if (armed_q && tick) begin
            ms_q <= ms_q + 32'd1;
            if (ms_q + 32'd1 >= (lim_ms >> 1)) half_q <= 1'b1;
         end
      end
   end

   // sticky status, set beats clear, survives system reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat0_q <= 8'h00;
         stat1_q <= 8'h00;
      end else if (ce) begin
         stat0_q[S0_1V8]  <= pin_s[5] | (stat0_q[S0_1V8] & ~wr_s0);
         stat0_q[S0_1V35] <= pin_s[6] | (stat0_q[S0_1V35] & ~wr_s0);
         stat1_q[S1_WDRST] <= expire | (stat1_q[S1_WDRST] & ~wr_s1);
         stat1_q[S1_5V]   <= pin_s[7] | (stat1_q[S1_5V] & ~wr_s1);
         stat1_q[S1_3V3]  <= pin_s[8] | (stat1_q[S1_3V3] & ~wr_s1);
      end
   end

   // outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         green_led_on    <= 1'b0;
         red_led_blink   <= 1'b0;
         sys_reset_req   <= 1'b0;
         power_event_req <= 1'b0;
      end else if (ce) begin
         green_led_on    <= ctrl_q[B_GREEN];
         red_led_blink   <= ctrl_q[B_RED];
         sys_reset_req   <= sysrst_q;
         power_event_req <= hs_edge && !ctrl_q[B_HRST];
      end
   end

   // checks
   AST_CTRL_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      ce && sysrst_q |=> ctrl_q == CTRL_RESET) else $error("ctrl not cleared");
   AST_GREEN: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> green_led_on == $past(ctrl_q[B_GREEN])) else $error("green led mismatch");
   AST_RED: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> red_led_blink == $past(ctrl_q[B_RED])) else $error("red led mismatch");
   AST_KICK_ARMS: assert property (@(posedge clk) disable iff (!rst_n)
      ce && kick && !sysrst_q |=> armed_q && !half_q && ms_q == 0) else $error("kick failed");
   AST_IDLE_NO_EXPIRE: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !armed_q && !kick |=> !armed_q) else $error("watchdog armed without kick");
   AST_EXPIRE_RST: assert property (@(posedge clk) disable iff (!rst_n)
      ce && expire ##1 ce |=> sys_reset_req && stat1_q[S1_WDRST]) else $error("expiry no reset");
   AST_SYSRST_DISARM: assert property (@(posedge clk) disable iff (!rst_n)
      ce && sysrst_q |=> !armed_q && !half_q) else $error("armed after reset");
   AST_RSVD0: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> (stat0_q & 8'h6F) == 8'h00 && s1_view[2:1] == 2'b00) else $error("reserved bits set");
   AST_HDIS: assert property (@(posedge clk) disable iff (!rst_n)
      ce && ctrl_q[B_HDIS] |=> !power_event_req) else $error("disabled switch acted");
   AST_HRST_NO_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
      ce && ctrl_q[B_HRST] |=> !power_event_req) else $error("reset route gave power event");
   AST_STICKY_1V8: assert property (@(posedge clk) disable iff (!rst_n)
      ce && stat0_q[S0_1V8] && !wr_s0 |=> stat0_q[S0_1V8]) else $error("status 0 flag lost");
   AST_STICKY_WD: assert property (@(posedge clk) disable iff (!rst_n)
      ce && stat1_q[S1_WDRST] && !wr_s1 |=> stat1_q[S1_WDRST]) else $error("status 1 flag lost");
   AST_HALF_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !armed_q |=> !half_q) else $error("half flag without armed watchdog");
   COV_KICK: cover property (@(posedge clk) kick);
   COV_EXPIRE: cover property (@(posedge clk) expire);
   COV_READ: cover property (@(posedge clk) st_q == ST_RDAT);
   COV_POWER_EVENT: cover property (@(posedge clk) power_event_req);
   COV_SW_RESET: cover property (@(posedge clk) wr_ctrl && byte_in[B_SWRST]);
endmodule : bcs_top
`default_nettype wire

/* File: verification/bcs_host_model.sv */
// smbus host controller model: clock and open-drain data
`timescale 1ns/1ns
`default_nettype none
module bcs_host_model (
   // bus lines, data pulled up outside
   output var  logic scl,
   output var  logic sda_oe,
   input  wire logic sda
);
   initial begin
      scl    = 1'b1;
      sda_oe = 1'b0;
   end
   // data moves only while clock is low
   task automatic bit_io(input logic b, output logic s);
      sda_oe = ~b;
      #40 scl = 1'b1;
      #40 s = sda;
      #40 scl = 1'b0;
      #40;
   endtask : bit_io
   // eight bits msb first, then release for ack or send nack
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
         q[i] = s;
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : byte_io
   task automatic start();
      sda_oe = 1'b1;
      #40 scl = 1'b0;
      #40;
   endtask : start
   task automatic stop();
      sda_oe = 1'b1;
      #40 scl = 1'b1;
      #40 sda_oe = 1'b0;
      #80;
   endtask : stop
   // byte data write only
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ack);
      logic [7:0] q;
      logic       k;
      start();
      byte_io({a, 1'b0}, q, ack);
      byte_io(c, q, k);
      byte_io(d, q, k);
      stop();
   endtask : wr
   // byte data read with repeated start
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      logic ack;
      start();
      byte_io({bcs_pkg::SLAVE_ADDR, 1'b0}, d, ack);
      byte_io(c, d, ack);
      sda_oe = 1'b0;
      #40 scl = 1'b1;
      #40;
      start();
      byte_io({bcs_pkg::SLAVE_ADDR, 1'b1}, d, ack);
      byte_io(8'hFF, d, ack);
      stop();
   endtask : rd
endmodule : bcs_host_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the board control and status block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import bcs_pkg::*;
   localparam logic [7:0] REV = 8'h3C; // arbitrary value
   logic       clk             = 1'b0;
   logic       rst_n           = 1'b0;
   logic       ce              = 1'b1;
   logic [4:0] rails           = 5'h00;
   logic       handle          = 1'b0;
   logic       scl;
   logic       host_oe;
   logic       dat_out;
   logic       dat_oe;
   logic       green;
   logic       red;
   logic       sys_rst;
   logic       pwr_ev;
   logic       rst_q           = 1'b0;
   logic       pe_q            = 1'b0;
   int         fail_count      = 0;
   int         samples_checked = 0;
   int         rst_cnt         = 0;
   int         pe_cnt          = 0;
   wire        sda;
   assign sda = ~(host_oe | (dat_oe & ~dat_out));
   always #5 clk = ~clk;
   // count rising edges of the two event outputs
   always @(posedge clk) begin
      rst_q <= sys_rst;
      pe_q  <= pwr_ev;
      if (sys_rst === 1'b1 && rst_q !== 1'b1) rst_cnt++;
      if (pwr_ev === 1'b1 && pe_q !== 1'b1) pe_cnt++;
   end
   bcs_host_model host_u (.scl(scl), .sda_oe(host_oe), .sda(sda));
   bcs_top #(.REVISION(REV), .TICK_CYCLES(10)) dut_u (
      .clk(clk), .rst_n(rst_n), .ce(ce), .smb_clk_in(scl), .smb_dat_in(sda),
      .smb_dat_out(dat_out), .smb_dat_oe(dat_oe), .rail_1v8_fail(rails[4]), .rail_1v35_fail(rails[3]),
      .rail_5v_fail(rails[2]), .rail_3v3_fail(rails[1]), .rail_12v_absent(rails[0]),
      .handle_switch(handle), .green_led_on(green), .red_led_blink(red),
      .sys_reset_req(sys_rst), .power_event_req(pwr_ev));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      logic ack;
      @(negedge clk);
      host_u.wr(SLAVE_ADDR, c, d, ack);
      check("ack", 8'h01, {7'h00, ack});
   endtask : wr
   task automatic rd_chk(input string what, input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] d;
      @(negedge clk);
      host_u.rd(c, d);
      check(what, exp, d);
   endtask : rd_chk
   task automatic set_in(input logic [4:0] r, input logic h);
      @(posedge clk);
      rails  <= r;
      handle <= h;
      cyc(20);
   endtask : set_in
   task automatic t_reset();
      rd_chk("ctrl", CMD_CTRL_RD, CTRL_RESET);
      rd_chk("rev", CMD_REV_RD, REV);
      rd_chk("stat0", STATUS_REG_ZERO_RD, 8'h00);
      rd_chk("stat1", WATCHDOG_RAIL_STATUS_READ, 8'h00);
      $display("done reset values");
   endtask : t_reset
   task automatic t_ctrl();
      logic ack;
      wr(CMD_CTRL_WR, 8'h82);
      cyc(4);
      check("green", 8'h01, {7'h00, green});
      check("red", 8'h01, {7'h00, red});
      rd_chk("ctrl", CMD_CTRL_RD, 8'h82);
      @(negedge clk);
      host_u.wr(7'h5D, CMD_CTRL_WR, 8'h00, ack);
      check("foreign ack", 8'h00, {7'h00, ack});
      rd_chk("ctrl kept", CMD_CTRL_RD, 8'h82);
      wr(CMD_REV_RD, 8'h55);
      rd_chk("rev kept", CMD_REV_RD, REV);
      wr(CMD_CTRL_WR, 8'h00);
      cyc(4);
      check("green off", 8'h00, {7'h00, green});
      check("red off", 8'h00, {7'h00, red});
      $display("done control");
   endtask : t_ctrl
   task automatic t_status();
      int r0;
      set_in(5'h1E, 1'b0);
      set_in(5'h00, 1'b0);
      rd_chk("stat0", STATUS_REG_ZERO_RD, 8'h90);
      rd_chk("stat1", WATCHDOG_RAIL_STATUS_READ, 8'h09);
      r0 = rst_cnt;
      wr(CMD_CTRL_WR, 8'h01);
      cyc(20);
      check("sw reset", 8'h01, 8'(rst_cnt - r0));
      rd_chk("ctrl", CMD_CTRL_RD, 8'h00);
      rd_chk("stat0 kept", STATUS_REG_ZERO_RD, 8'h90);
      rd_chk("stat1 kept", WATCHDOG_RAIL_STATUS_READ, 8'h09);
      wr(STATUS_REG_ZERO_WR, 8'h5A);
      rd_chk("stat0 clr", STATUS_REG_ZERO_RD, 8'h00);
      wr(WATCHDOG_RAIL_STATUS_CLEAR, 8'hFF);
      rd_chk("stat1 clr", WATCHDOG_RAIL_STATUS_READ, 8'h00);
      set_in(5'h01, 1'b0);
      rd_chk("12v", WATCHDOG_RAIL_STATUS_READ, 8'h10);
      set_in(5'h00, 1'b0);
      $display("done status");
   endtask : t_status
   task automatic t_handle();
      int p0;
      int r0;
      p0 = pe_cnt;
      r0 = rst_cnt;
      set_in(5'h00, 1'b1);
      set_in(5'h00, 1'b0);
      check("power event", 8'h01, 8'(pe_cnt - p0));
      wr(CMD_CTRL_WR, 8'h40);
      set_in(5'h00, 1'b1);
      set_in(5'h00, 1'b0);
      check("disabled", 8'h01, 8'(pe_cnt - p0 + rst_cnt - r0));
      wr(CMD_CTRL_WR, 8'h20);
      set_in(5'h00, 1'b1);
      set_in(5'h00, 1'b0);
      check("handle rst", 8'h01, 8'(rst_cnt - r0));
      check("no event", 8'h01, 8'(pe_cnt - p0));
      $display("done handle");
   endtask : t_handle
   task automatic t_wd();
      int r0;
      wr(CMD_CTRL_WR, 8'h04);
      rd_chk("armed", WATCHDOG_RAIL_STATUS_READ, 8'h80);
      cyc(11000);
      rd_chk("half", WATCHDOG_RAIL_STATUS_READ, 8'hA0);
      wr(CMD_CTRL_WR, 8'h00);
      rd_chk("kicked", WATCHDOG_RAIL_STATUS_READ, 8'h80);
      r0 = rst_cnt;
      cyc(8000);
      rd_chk("restarted", WATCHDOG_RAIL_STATUS_READ, 8'h80);
      cyc(12000);
      check("expiry", 8'h01, 8'(rst_cnt - r0));
      rd_chk("cause", WATCHDOG_RAIL_STATUS_READ, 8'h40);
      wr(WATCHDOG_RAIL_STATUS_CLEAR, 8'h00);
      r0 = rst_cnt;
      wr(CMD_CTRL_WR, 8'h14);
      cyc(21000);
      check("long interval", 8'h00, 8'(rst_cnt - r0));
      rd_chk("no half", WATCHDOG_RAIL_STATUS_READ, 8'h80);
      wr(CMD_CTRL_WR, 8'h01);
      cyc(20);
      rd_chk("disarmed", WATCHDOG_RAIL_STATUS_READ, 8'h00);
      $display("done watchdog");
   endtask : t_wd
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   initial begin
      cyc(3);
      rst_n <= 1'b1;
      cyc(8);
      t_reset();
      t_ctrl();
      t_status();
      t_handle();
      t_wd();
      complete_run();
   end
   initial begin
      #1_000_000;
      fail_count++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
